// ==== src/ftxlc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// 100BASE-TX line coder: MII beats in, MLT-3 levels out,
// plus receive code-group interpretation toward the MAC.
module ftxlc_top (
  input  wire logic        i_core_clk,   // Single core clock
  input  wire logic        i_srst,       // Sync reset, active high
  input  wire logic [4:0]  i_phy_addr,   // Seeds the scrambler
  input  wire logic        i_tx_valid,   // MII beat offered
  output var  logic        o_tx_ready,   // FIFO has room
  input  wire logic        i_tx_en,      // Transmit enable
  input  wire logic        i_tx_er,      // Transmit error
  input  wire logic [3:0]  i_txd,        // Transmit nibble
  output var  logic        o_nrzi,       // NRZI serial level
  output var  logic [1:0]  o_mlt3,       // Three-level output
  input  wire logic        i_rx_cg_valid, // Aligned code-group strobe
  input  wire logic [4:0]  i_rx_cg,      // Received code-group
  output var  logic [3:0]  o_rxd,        // Receive nibble
  output var  logic        o_rx_dv,      // Receive data valid
  output var  logic        o_rx_er,      // Receive error
  output var  logic        o_crs         // Carrier sense
);
  typedef enum logic [2:0] {
    TX_IDLE, TX_J, TX_DATA, TX_T
  } ftxlc_tx_type;
  typedef enum logic [1:0] {
    RX_IDLE, RX_SSD, RX_FRAME, RX_ESD
  } ftxlc_rx_type;

  ftxlc_pkg::ftxlc_beat_type in_beat, head; // FIFO ends
  logic head_valid;                         // FIFO not empty
  logic pop;                                // Take head beat

  assign in_beat = '{en: i_tx_en, er: i_tx_er, nib: i_txd};

  // Eight-beat buffer absorbs MAC bursts between group slots
  ftxlc_fifo #(
    .W ($bits(ftxlc_pkg::ftxlc_beat_type)),
    .D (ftxlc_pkg::FIFO_D)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_srst      (i_srst),
    .i_in_valid  (i_tx_valid),
    .o_in_ready  (o_tx_ready),
    .i_in_data   (in_beat),
    .o_out_valid (head_valid),
    .i_out_ready (pop),
    .o_out_data  (head)
  );

  // Transmit state
  ftxlc_tx_type                  tx_st, next_tx_st;   // Delimiter phase
  logic [2:0]                    bit_cnt, next_bit_cnt; // Bit slot
  logic [4:0]                    shreg, next_shreg;   // Serialiser
  logic [ftxlc_pkg::LFSR_W-1:0]  lfsr, next_lfsr;     // Scrambler
  logic                          next_nrzi;
  logic [1:0]                    next_mlt3;
  logic                          mlt_up, next_mlt_up; // Ramp direction
  logic [4:0]                    cg;                  // Group chosen
  logic                          lfsr_fb;
  logic                          sbit;                // Scrambled bit

  // Group selection, serialise, scramble, NRZI and MLT-3
  always_comb
  begin
    next_tx_st   = tx_st;
    pop          = 1'b0;
    cg           = ftxlc_pkg::CG_IDLE;
    next_bit_cnt = bit_cnt + 3'h1;
    next_shreg   = {shreg[3:0], 1'b0};
    if (bit_cnt == ftxlc_pkg::BIT_LAST)
    begin
      // New code-group is chosen only at a group boundary
      next_bit_cnt = '0;
      unique case (tx_st)
        TX_IDLE:
        begin
          // Idle repeats until enable rises
          if (head_valid && head.en)
          begin
            cg         = ftxlc_pkg::CG_J;
            next_tx_st = TX_J;
          end
          pop = head_valid; // Stray beats without enable dropped
        end
        TX_J:
        begin
          cg         = ftxlc_pkg::CG_K;
          pop        = head_valid;      // Second preamble nibble
          next_tx_st = TX_DATA;
        end
        TX_DATA:
        begin
          // Underflow also ends the frame; keep the FIFO fed
          if (head_valid && head.en)
          begin
            // Only table or H groups, never invalid ones
            cg  = head.er ? ftxlc_pkg::CG_H
                          : ftxlc_pkg::ENC_TAB[head.nib];
            pop = 1'b1;
          end
          else
          begin
            cg         = ftxlc_pkg::CG_T;
            next_tx_st = TX_T;
          end
        end
        TX_T:
        begin
          cg         = ftxlc_pkg::CG_R;
          next_tx_st = TX_IDLE;
        end
      endcase
      next_shreg = cg;
    end
    // Serial bit XOR keystream, idle included
    lfsr_fb   = ^(lfsr & ftxlc_pkg::LFSR_TAP);
    next_lfsr = {lfsr[9:0], lfsr_fb};
    sbit      = shreg[4] ^ lfsr[10];
    next_nrzi = o_nrzi ^ sbit;
    // MLT-3 cycle 0,+,0,-; a one steps, a zero holds
    next_mlt3   = o_mlt3;
    next_mlt_up = mlt_up;
    if (sbit)
    begin
      unique case (o_mlt3)
        ftxlc_pkg::MLT_ZERO:
          next_mlt3 = mlt_up ? ftxlc_pkg::MLT_POS : ftxlc_pkg::MLT_NEG;
        ftxlc_pkg::MLT_POS:
        begin
          next_mlt3   = ftxlc_pkg::MLT_ZERO;
          next_mlt_up = 1'b0;
        end
        default:
        begin
          next_mlt3   = ftxlc_pkg::MLT_ZERO;
          next_mlt_up = 1'b1;
        end
      endcase
    end
  end

  // Transmit registers, all on the core clock
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      tx_st   <= TX_IDLE;
      bit_cnt <= ftxlc_pkg::BIT_LAST; // First group loads at once
      shreg   <= ftxlc_pkg::CG_IDLE;
      // Sync reset may sample the address; top bit forces nonzero
      lfsr    <= {ftxlc_pkg::SEED_HIGH, i_phy_addr};
      o_nrzi  <= 1'b0;
      o_mlt3  <= ftxlc_pkg::MLT_ZERO;
      mlt_up  <= 1'b1;
    end
    else
    begin
      tx_st   <= next_tx_st;
      bit_cnt <= next_bit_cnt;
      shreg   <= next_shreg;
      lfsr    <= next_lfsr;
      o_nrzi  <= next_nrzi;
      o_mlt3  <= next_mlt3;
      mlt_up  <= next_mlt_up;
    end
  end

  // Receive state
  ftxlc_rx_type rx_st, next_rx_st;  // Frame phase
  logic         idle_seen, next_idle_seen; // One idle already
  logic [3:0]   next_rxd;
  logic         next_dv, next_er, next_crs;
  logic         dec_ok;             // Group is a data group
  logic [3:0]   dec_nib;            // Its nibble

  // Reverse table lookup; a loop keeps it one place
  always_comb
  begin
    dec_ok  = 1'b0;
    dec_nib = ftxlc_pkg::NIB_ZERO;
    for (int n = 0; n < 16; n++)
    begin
      if (ftxlc_pkg::ENC_TAB[n] == i_rx_cg)
      begin
        dec_ok  = 1'b1;
        dec_nib = 4'(n);
      end
    end
  end

  // Receive interpretation toward the MAC
  always_comb
  begin
    next_rx_st     = rx_st;
    next_idle_seen = 1'b0;
    next_rxd       = o_rxd;
    next_dv        = o_rx_dv;
    next_er        = 1'b0;
    next_crs       = o_crs;
    if (i_rx_cg_valid)
    begin
      unique case (rx_st)
        RX_IDLE:
        begin
          if (i_rx_cg == ftxlc_pkg::CG_J)
          begin
            next_rx_st = RX_SSD;
            next_crs   = 1'b1;
          end
        end
        RX_SSD:
        begin
          if (i_rx_cg == ftxlc_pkg::CG_K)
          begin
            next_rx_st = RX_FRAME;
            next_dv    = 1'b1;
            next_rxd   = ftxlc_pkg::NIB_SSD;
          end
          else
          begin
            // Bad SSD: error with 1110, valid stays low
            next_rx_st = RX_IDLE;
            next_er    = 1'b1;
            next_rxd   = ftxlc_pkg::NIB_BAD;
            next_crs   = 1'b0;
          end
        end
        RX_FRAME:
        begin
          if (dec_ok)
            next_rxd = dec_nib;
          else if (i_rx_cg == ftxlc_pkg::CG_T)
            next_rx_st = RX_ESD;
          else if (i_rx_cg == ftxlc_pkg::CG_IDLE && idle_seen)
          begin
            // Two idles close the frame without an error
            next_rx_st = RX_IDLE;
            next_dv    = 1'b0;
            next_crs   = 1'b0;
          end
          else if (i_rx_cg == ftxlc_pkg::CG_IDLE)
            next_idle_seen = 1'b1;
          else
            next_er = 1'b1; // Stray R, J, K, H or invalid
        end
        RX_ESD:
        begin
          if (i_rx_cg == ftxlc_pkg::CG_R)
          begin
            next_rx_st = RX_IDLE;
            next_dv    = 1'b0;
            next_crs   = 1'b0;
          end
          else
          begin
            // A repeated T is flagged but may still pair with its R
            if (i_rx_cg == ftxlc_pkg::CG_T)
              next_rx_st = RX_ESD;
            else
              next_rx_st = RX_FRAME;
            next_er    = 1'b1;
          end
        end
      endcase
    end
    else
      next_idle_seen = idle_seen;
  end

  // Receive registers
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      rx_st     <= RX_IDLE;
      idle_seen <= 1'b0;
      o_rxd     <= ftxlc_pkg::NIB_ZERO;
      o_rx_dv   <= 1'b0;
      o_rx_er   <= 1'b0;
      o_crs     <= 1'b0;
    end
    else
    begin
      rx_st     <= next_rx_st;
      idle_seen <= next_idle_seen;
      o_rxd     <= next_rxd;
      o_rx_dv   <= next_dv;
      o_rx_er   <= next_er;
      o_crs     <= next_crs;
    end
  end
endmodule // ftxlc_top
`default_nettype wire

// ==== src/ftxlc_pkg.sv ====
// Summary of operation
// - Data nibbles map to fixed 5-bit code-groups
// - Idle code-groups repeat after T R until enable
// - R after T drops carrier; otherwise receive error
// - Invalid groups flag receive error except in idle; never transmitted
// - J raises carrier only; K delivered as 0101, valid asserts
// - Every outgoing code-group, idle included, is scrambled
// - A separate shift register converts parallel groups to serial
// - Scrambler seed derived from the PHY address
// - Scrambled bits become NRZI, one means toggle
// - MLT-3 steps level on one, holds on zero
// - All transmit logic on the single core clock
`default_nettype none
package ftxlc_pkg;
  localparam int        NIB_W     = 4;    // MII nibble width
  localparam int        CG_W      = 5;    // Code-group width
  localparam int        FIFO_D    = 8;    // Transmit FIFO depth
  localparam int        LFSR_W    = 11;   // Scrambler length
  localparam int        PHYA_W    = 5;    // PHY address width
  localparam logic [2:0] BIT_LAST = 3'h4; // Last bit slot of a group
  // Control code-groups
  localparam logic [4:0] CG_IDLE  = 5'h1f;
  localparam logic [4:0] CG_J     = 5'h18;
  localparam logic [4:0] CG_K     = 5'h11;
  localparam logic [4:0] CG_T     = 5'h0d;
  localparam logic [4:0] CG_R     = 5'h07;
  localparam logic [4:0] CG_H     = 5'h04;
  // Nibbles shown to the MAC
  localparam logic [3:0] NIB_SSD  = 4'h5;
  localparam logic [3:0] NIB_BAD  = 4'he;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  // Scrambler taps and seed padding (seed never all zero)
  localparam logic [10:0] LFSR_TAP  = 11'h500;
  localparam logic [5:0]  SEED_HIGH = 6'h21;
  // Data code-groups indexed by nibble
  localparam logic [4:0] ENC_TAB [16] = '{
    5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  // One MII transmit beat
  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] nib;
  } ftxlc_beat_type;
  // MLT-3 line levels
  typedef enum logic [1:0] {
    MLT_ZERO = 2'h0,
    MLT_POS  = 2'h1,
    MLT_NEG  = 2'h3
  } ftxlc_mlt_type;
endpackage
`default_nettype wire

// ==== src/ftxlc_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
// Small synchronous FIFO; ready and valid are honest on both sides
module ftxlc_fifo #(
  parameter int W = 6,
  parameter int D = 8
) (
  input  wire logic         i_core_clk,
  input  wire logic         i_srst,
  input  wire logic         i_in_valid,
  output var  logic         o_in_ready,
  input  wire logic [W-1:0] i_in_data,
  output var  logic         o_out_valid,
  input  wire logic         i_out_ready,
  output var  logic [W-1:0] o_out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];               // Storage
  logic [AW-1:0] wp, rp, next_wp, next_rp; // Pointers
  logic [AW:0]   cnt, next_cnt;        // Fill level
  logic          next_ready;
  logic          push, pop;
  // Pointer and level update
  always_comb
  begin
    push       = i_in_valid && o_in_ready;
    pop        = o_out_valid && i_out_ready;
    next_wp    = push ? wp + 1'b1 : wp;
    next_rp    = pop ? rp + 1'b1 : rp;
    next_cnt   = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    // Registered ready so the source sees a clean level
    next_ready = next_cnt != (AW+1)'(D);
  end
  always_ff @(posedge i_core_clk)
  begin
    if (i_srst)
    begin
      wp         <= '0;
      rp         <= '0;
      cnt        <= '0;
      o_in_ready <= 1'b0;
    end
    else
    begin
      wp         <= next_wp;
      rp         <= next_rp;
      cnt        <= next_cnt;
      o_in_ready <= next_ready;
    end
  end
  // Data array write, no reset needed
  always_ff @(posedge i_core_clk)
  begin
    if (push)
      mem[wp] <= i_in_data;
  end
  assign o_out_valid = cnt != '0;
  assign o_out_data  = mem[rp];
endmodule // ftxlc_fifo
`default_nettype wire

// ==== sim/ftxlc_mac_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// MAC side of the MII: offers beats and holds each until taken
module ftxlc_mac_model (
  input  wire logic       i_core_clk,
  input  wire logic       i_ready,
  output var  logic       o_valid,
  output var  logic       o_en,
  output var  logic       o_er,
  output var  logic [3:0] o_txd
);
  // Quiet until a frame is asked for
  initial
  begin
    o_valid = 1'b0;
    o_en = 1'b0;
    o_er = 1'b0;
    o_txd = 4'h0;
  end
  // Preamble byte, then n data nibbles; error flag on beat e
  task automatic send(input int n, input int e);
    for (int i = 0; i < n + 2; i++)
    begin
      @(negedge i_core_clk);
      o_valid = 1'b1;
      o_en = 1'b1;
      o_er = (i == e);
      o_txd = (i < 2) ? 4'h5 : 4'(i - 2);
      // Ready is registered, so its value now is what the edge sees
      while (!i_ready)
        @(negedge i_core_clk);
      @(posedge i_core_clk);
    end
    @(negedge i_core_clk);
    o_valid = 1'b0;
    o_en = 1'b0;
    o_txd = ~o_txd; // Stale data must not look valid
  endtask
endmodule // ftxlc_mac_model
`default_nettype wire

// ==== sim/ftxlc_top_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
// Line level and receive interpretation relations
module ftxlc_top_properties (
  input wire logic       i_core_clk,
  input wire logic       i_srst,
  input wire logic       o_nrzi,
  input wire logic [1:0] o_mlt3,
  input wire logic       i_rx_cg_valid,
  input wire logic [4:0] i_rx_cg,
  input wire logic [3:0] o_rxd,
  input wire logic       o_rx_dv,
  input wire logic       o_rx_er,
  input wire logic       o_crs
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  // One received code-group strobe
  sequence cg_s(c);
    i_rx_cg_valid && i_rx_cg == c;
  endsequence
  // Start delimiter taken from idle
  sequence ssd_s;
    cg_s(5'h18) ##0 !o_crs ##1 cg_s(5'h11);
  endsequence
  // End delimiter inside a frame
  sequence esd_s;
    o_rx_dv ##0 cg_s(5'h0d) ##1 cg_s(5'h07);
  endsequence
  mlt_step_a: assert property (
    $changed(o_nrzi) |-> $changed(o_mlt3))
    else $error("level missed a step");
  mlt_hold_a: assert property (
    !$changed(o_nrzi) |-> $stable(o_mlt3))
    else $error("level moved on a zero");
  mlt_return_a: assert property (
    $past(o_mlt3) != 2'h0 && $changed(o_mlt3) |-> o_mlt3 == 2'h0)
    else $error("level skipped zero");
  ssd_valid_a: assert property (
    ssd_s |=> o_rx_dv && o_rxd == 4'h5)
    else $error("start pair not delivered");
  ssd_carrier_a: assert property (
    cg_s(5'h18) ##0 !o_crs |=> o_crs && !o_rx_dv)
    else $error("carrier not raised");
  esd_drop_a: assert property (
    esd_s |=> !o_rx_dv && !o_crs && !o_rx_er)
    else $error("end pair did not drop carrier");
  bad_code_a: assert property (
    o_rx_dv && i_rx_cg_valid && i_rx_cg inside {5'h00, 5'h06, 5'h10}
    |=> o_rx_er)
    else $error("invalid group not flagged");
  stray_end_a: assert property (
    o_rx_dv && $past(i_rx_cg_valid) && $past(i_rx_cg) != 5'h0d
    ##0 cg_s(5'h07) |=> o_rx_er)
    else $error("lone end group not flagged");
endmodule // ftxlc_top_properties
bind ftxlc_top ftxlc_top_properties u_props (
  .i_core_clk, .i_srst, .o_nrzi, .o_mlt3, .i_rx_cg_valid,
  .i_rx_cg, .o_rxd, .o_rx_dv, .o_rx_er, .o_crs);
`default_nettype wire

// ==== sim/ftxlc_top_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
// Sends frames, decodes the line back, drives received groups
module ftxlc_top_bench;
  localparam logic [4:0] TAB [16] = '{5'h1e, 5'h09, 5'h14, 5'h15,
    5'h0a, 5'h0b, 5'h0e, 5'h0f, 5'h12, 5'h13, 5'h16, 5'h17,
    5'h1a, 5'h1b, 5'h1c, 5'h1d};
  localparam logic [4:0] EXT [5] = '{5'h04, 5'h0d, 5'h07, 5'h1f, 5'h1f};
  // Group sent, expected {dv,er,crs,ready,rxd}, compare mask
  localparam logic [20:0] RXV [24] = '{{5'h18, 8'h30, 8'hff},
    {5'h11, 8'hb5, 8'hff}, {5'h1e, 8'hb0, 8'hff}, {5'h09, 8'hb1, 8'hff},
    {5'h00, 8'hf0, 8'hf0}, {5'h06, 8'hf0, 8'hf0}, {5'h10, 8'hf0, 8'hf0},
    {5'h1d, 8'hbf, 8'hff}, {5'h0d, 8'hbf, 8'hff}, {5'h07, 8'h1f, 8'hff},
    {5'h18, 8'h3f, 8'hff}, {5'h1e, 8'h5e, 8'hff}, {5'h18, 8'h3e, 8'hff},
    {5'h11, 8'hb5, 8'hff}, {5'h07, 8'hf0, 8'hf0}, {5'h0d, 8'hb0, 8'hf0},
    {5'h09, 8'hf0, 8'hf0}, {5'h1f, 8'hb0, 8'hf0}, {5'h1f, 8'h10, 8'hf0},
    {5'h18, 8'h35, 8'hff}, {5'h11, 8'hb5, 8'hff}, {5'h0d, 8'hb5, 8'hff},
    {5'h0d, 8'hf0, 8'hf0}, {5'h07, 8'h10, 8'hf0}};
  logic        i_core_clk = 1'b0;
  logic        i_srst = 1'b1;
  logic [4:0]  i_phy_addr = 5'h00;
  logic        i_rx_cg_valid = 1'b0;
  logic [4:0]  i_rx_cg = 5'h1f;
  logic        tx_valid, tx_en, tx_er, o_tx_ready, o_nrzi;
  logic        o_rx_dv, o_rx_er, o_crs, full;
  logic        pn = 1'b0;     // Previous line level
  logic [3:0]  txd, o_rxd;
  logic [1:0]  o_mlt3;
  logic [10:0] lf;            // Keystream model
  logic        b [$];         // Bits recovered from level toggles
  logic        k [$];         // Keystream bits, same cycles
  int          err_total = 0;
  int          cmp_count = 0;
  ftxlc_top DUT (.i_core_clk, .i_srst, .i_phy_addr, .i_tx_valid(tx_valid),
    .o_tx_ready, .i_tx_en(tx_en), .i_tx_er(tx_er), .i_txd(txd), .o_nrzi,
    .o_mlt3, .i_rx_cg_valid, .i_rx_cg, .o_rxd, .o_rx_dv, .o_rx_er, .o_crs);
  ftxlc_mac_model MAC (.i_core_clk, .i_ready(o_tx_ready),
    .o_valid(tx_valid), .o_en(tx_en), .o_er(tx_er), .o_txd(txd));
  // One clock for everything
  always #5 i_core_clk = ~i_core_clk;
  // Seed from the address, one shift per clock
  always @(posedge i_core_clk)
  begin
    lf <= i_srst ? {6'h21, i_phy_addr} : {lf[9:0], lf[10] ^ lf[8]};
    if (tx_valid && !o_tx_ready)
      full <= 1'b1; // FIFO refused a beat
  end
  // Record line bits where outputs are settled
  always @(negedge i_core_clk)
  begin
    b.push_back(o_nrzi ^ pn);
    k.push_back(lf[10]);
    pn = o_nrzi;
  end
  task automatic chk_cg(input logic [4:0] g, input logic [4:0] e);
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_st(input logic [7:0] e, input logic [7:0] m);
    logic [7:0] g;
    g = {o_rx_dv, o_rx_er, o_crs, o_tx_ready, o_rxd} & m;
    cmp_count++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR %0t status %h want %h", $time, g, e);
    end
  endtask
  // Reset with a given address; outputs must be quiet
  task automatic do_reset(input logic [4:0] a);
    @(negedge i_core_clk);
    i_srst = 1'b1;
    i_phy_addr = a;
    repeat (2) @(negedge i_core_clk);
    chk_st(8'h00, 8'hff);
    chk_cg({2'h0, o_mlt3, o_nrzi}, 5'h00);
    i_srst = 1'b0;
    b.delete();
    k.delete();
    full = 1'b0;
  endtask
  // Frame with every nibble and an error beat, decoded off the line
  task automatic tx_frame(input logic [4:0] a);
    logic [19:0] w;
    int p;
    int off;
    do_reset(a);
    repeat (20) @(negedge i_core_clk);
    MAC.send(17, 18);
    repeat (150) @(negedge i_core_clk);
    p = -1;
    off = 0;
    // Idle then J K locates both keystream phase and group edge
    for (int o = 0; o < 8 && p < 0; o++)
      for (int q = 8; q < 100 && p < 0; q++)
      begin
        for (int j = 0; j < 20; j++)
          w = {w[18:0], b[q + j] ^ k[q + j - o]};
        if (w === 20'hfff11)
        begin
          p = q + 20;
          off = o;
        end
      end
    chk_cg({4'h0, p >= 0}, 5'h01);
    for (int g = 0; g < 21 && p >= 0; g++)
    begin
      for (int j = 0; j < 5; j++)
        w = {w[18:0], b[p + 5 * g + j] ^ k[p + 5 * g + j - off]};
      chk_cg(w[4:0], g < 16 ? TAB[g] : EXT[g - 16]);
    end
    chk_cg({4'h0, full}, 5'h01);
    chk_cg({4'h0, o_tx_ready}, 5'h01);
  endtask
  // Back-to-back received groups: frames, errors, bad start
  task automatic rx_frames;
    @(negedge i_core_clk);
    foreach (RXV[i])
    begin
      i_rx_cg_valid = 1'b1;
      i_rx_cg = RXV[i][20:16];
      @(negedge i_core_clk);
      chk_st(RXV[i][15:8], RXV[i][7:0]);
    end
    i_rx_cg_valid = 1'b0;
    i_rx_cg = ~i_rx_cg;
  endtask
  task automatic complete_run;
    $display("TB counts: %0d compared, %0d errors", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence; the second reset lands after the first frame has gone out and been checked
  initial
  begin
    tx_frame(5'h00);
    tx_frame(5'h13);
    rx_frames;
    complete_run;
  end
  // Watchdog well past the expected run
  initial
  begin
    #20000;
    err_total++;
    $display("ERROR %0t watchdog expired", $time);
    complete_run;
  end
endmodule // ftxlc_top_bench
`default_nettype wire
